// ---- core/sbd_pkg.sv ----
// shared constants and types for the bus decoder and slave response ends
// How it works
// (RULE_01) selects are combinational decode of upper address
// (RULE_02) slaves capture address and select only when ready
// (RULE_03) every slave region spans at least 1kB
// (RULE_04) masters never cross a 1kB boundary
// (RULE_05) unmapped sequential or nonsequential access gets error
// (RULE_06) unmapped idle or busy gets zero-wait okay
// (RULE_07) masters cannot abort a started transfer
// (RULE_08) selected slave drives response with ready
// (RULE_09) ready low stretches, high completes the transfer
// (RULE_10) wait states bounded, at most sixteen
// (RULE_11) response codes okay error retry split
// (RULE_12) response okay while waiting before final code
// (RULE_13) only okay completes in one cycle
// (RULE_14) error codes: ready low then high, same code
// (RULE_15) master cancels pipelined address after retry or split
// (RULE_16) master may abandon or continue burst after error
// (RULE_17) retry keeps normal arbitration priority
// (RULE_18) split lets lower masters win; arbiter told later
// (RULE_19) splitting slave requests bus when data ready
// (RULE_20) master reissues after retry or split until done
// (RULE_21) exactly one select, holes go to default
package sbd_pkg;
	localparam int unsigned ADDR_W       = 32;
	localparam int unsigned REGION_BITS  = 10;
	localparam int unsigned NUM_SLAVES   = 4;
	localparam int unsigned SEL_W        = NUM_SLAVES + 1;
	localparam int unsigned DEF_IDX      = NUM_SLAVES;
	localparam int unsigned MAX_WAIT     = 16;
	localparam int unsigned WAIT_W       = 5;
	localparam int unsigned REGION_SHIFT = 12;
	localparam int unsigned REGION_SEL_W = ADDR_W - REGION_SHIFT;
	localparam logic [REGION_SEL_W-1:0] REGION_BASE = 20'h00000;

	typedef enum logic [1:0] {
		SBD_TR_IDLE   = 2'b00,
		SBD_TR_BUSY   = 2'b01,
		SBD_TR_NONSEQ = 2'b10,
		SBD_TR_SEQ    = 2'b11
	} sbd_trans_e;

	typedef enum logic [1:0] {
		SBD_RESP_OKAY  = 2'b00,
		SBD_RESP_ERROR = 2'b01,
		SBD_RESP_RETRY = 2'b10,
		SBD_RESP_SPLIT = 2'b11
	} sbd_resp_e;

	function automatic logic sbd_is_active(input sbd_trans_e t);
		return (t == SBD_TR_NONSEQ) || (t == SBD_TR_SEQ);
	endfunction
endpackage

// ---- core/sbd_bus_if.sv ----
// interface joining the master side and the decoder/slave side
`timescale 1ns/1ps
`default_nettype none
interface sbd_bus_if;
	import sbd_pkg::*;
	logic [ADDR_W-1:0] haddr;
	sbd_trans_e        htrans;
	logic              hready;
	sbd_resp_e         hresp;
	logic [SEL_W-1:0]  hsel;
	logic              split_req;

	modport dev (input haddr, input htrans, output hready, output hresp, output hsel,
		output split_req);
	modport mst (output haddr, output htrans, input hready, input hresp, input hsel,
		input split_req);
endinterface
`default_nettype wire

// ---- core/sbd_decoder_slave.sv ----
// central decoder, default slave and a response-generating slave
`timescale 1ns/1ps
`default_nettype none
module sbd_decoder_slave
	import sbd_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset,
	sbd_bus_if.dev           bus,
	input  wire logic [WAIT_W-1:0] cfg_wait,
	input  wire sbd_resp_e   cfg_resp,
	input  wire logic        data_avail,
	output logic             sel_default,
	output logic             xfer_done
);
	// the decoder drives every select from the address alone, so a select
	// may change while ready is low; only the slave below decides when it
	// is allowed to look at it
	// the modelled slave takes its wait count and its final code from the
	// cfg inputs at the moment it needs them, so a caller may change them
	// between attempts of a retried transfer

	typedef enum logic [1:0] {
		SBD_ST_IDLE = 2'b00,
		SBD_ST_WAIT = 2'b01,
		SBD_ST_TWO  = 2'b10,
		SBD_ST_LAST = 2'b11
	} sbd_state_e;

	typedef struct packed {
		sbd_state_e        st;
		logic [WAIT_W-1:0] cnt;
		sbd_resp_e         resp;
		logic              ready;
		logic              split_pend;
		logic              split_req;
		logic              sel_def;
		logic              done;
	} sbd_dev_s;

	// bus idle, ready high with okay, nothing owed to a split master
	localparam sbd_dev_s DEV_INIT = '{
		st:         SBD_ST_IDLE,
		cnt:        '0,
		resp:       SBD_RESP_OKAY,
		ready:      1'b1,
		split_pend: 1'b0,
		split_req:  1'b0,
		sel_def:    1'b0,
		done:       1'b0
	};

	sbd_dev_s           r;
	sbd_dev_s           next_r;
	wire [SEL_W-1:0]    sel;
	logic               capture;
	logic               hole;

	// one region per slave, compared on the upper address bits only
	function automatic logic region_hit(
		input logic [ADDR_W-1:0] a,
		input int unsigned       idx
	);
		logic [REGION_SEL_W-1:0] upper;
		logic [REGION_SEL_W-1:0] offset;

		upper  = a[ADDR_W-1:REGION_SHIFT];
		offset = upper - REGION_BASE;
		return offset == REGION_SEL_W'(idx);
	endfunction

	// oversized requests are clamped so the bus can never be held for long
	function automatic logic [WAIT_W-1:0] clamp_wait(input logic [WAIT_W-1:0] w);
		logic [WAIT_W-1:0] lim;

		lim = WAIT_W'(MAX_WAIT);
		if (w > lim) begin
			return lim; // RULE_10
		end
		return w;
	endfunction

	// final decision: okay ends now, the other codes take two cycles
	function automatic sbd_dev_s decide(
		input sbd_dev_s  s,
		input sbd_resp_e fin
	);
		sbd_dev_s o;

		o      = s;
		o.resp = fin; // RULE_08 RULE_11
		if (fin == SBD_RESP_OKAY) begin
			o.ready = 1'b1;
			o.done  = 1'b1;
			o.st    = SBD_ST_TWO;
		end else begin
			o.ready = 1'b0; // RULE_13 RULE_14
			o.st    = SBD_ST_LAST;
			// a split leaves a debt that is paid once data is available
			if (fin == SBD_RESP_SPLIT) begin
				o.split_pend = 1'b1;
			end
		end
		return o;
	endfunction

	// start of a data phase, from idle or from the final cycle of the last one
	function automatic sbd_dev_s accept(
		input sbd_dev_s          s,
		input logic              to_hole,
		input logic [WAIT_W-1:0] w,
		input sbd_resp_e         fin
	);
		sbd_dev_s o;

		o         = s;
		o.sel_def = to_hole;
		if (to_hole) begin
			// holes never wait: the error starts in the very next cycle
			o.ready = 1'b0; // RULE_05
			o.resp  = SBD_RESP_ERROR;
			o.st    = SBD_ST_LAST;
		end else begin
			// an accepted transfer to a slave region, not a hole, settles any earlier split request
			o.split_req = 1'b0;
			o.cnt       = clamp_wait(w);
			if (o.cnt != '0) begin
				o.ready = 1'b0; // RULE_09 RULE_12
				o.resp  = SBD_RESP_OKAY;
				o.st    = SBD_ST_WAIT;
			end else begin
				o = decide(o, fin);
			end
		end
		return o;
	endfunction

	// combinational decode, 4kB regions sit above the 1kB floor
	for (genvar g = 0; g < NUM_SLAVES; g++) begin : gen_sel
		assign sel[g] = region_hit(bus.haddr, g); // RULE_01 RULE_03
	end

	// anything outside every region falls to the default slave
	assign sel[DEF_IDX] = ~|sel[NUM_SLAVES-1:0]; // RULE_21
	assign bus.hsel     = sel;

	// only a completing cycle may start a new data phase
	assign capture = bus.hready && sbd_is_active(bus.htrans); // RULE_02
	assign hole    = sel[DEF_IDX];

	always_comb begin
		next_r      = r;
		next_r.done = 1'b0;
		case (r.st)
			SBD_ST_IDLE, SBD_ST_TWO: begin
				// idle or busy cycles get a zero-wait okay, to holes as well
				next_r.ready = 1'b1; // RULE_06
				next_r.resp  = SBD_RESP_OKAY;
				next_r.st    = SBD_ST_IDLE;
				if (capture) begin
					next_r = accept(next_r, hole, cfg_wait, cfg_resp);
				end else if (bus.hready) begin
					next_r.sel_def = hole;
				end
			end
			SBD_ST_WAIT: begin
				// okay with ready low until the count runs out
				next_r.cnt = r.cnt - WAIT_W'(1);
				if (r.cnt == WAIT_W'(1)) begin
					next_r = decide(next_r, cfg_resp);
				end
			end
			SBD_ST_LAST: begin
				// same code again, now with ready high
				next_r.ready = 1'b1; // RULE_14
				next_r.st    = SBD_ST_TWO;
				next_r.done  = 1'b1;
			end
			default: begin
				// unreachable codes fall back to idle rather than hang the bus
				next_r.st = SBD_ST_IDLE;
			end
		endcase
		// released data wins over the clear made by an accepted transfer
		if (r.split_pend && data_avail) begin
			next_r.split_pend = 1'b0;
			next_r.split_req  = 1'b1; // RULE_19
		end
	end

	// reset loads constants only; the split request starts clear so no
	// grant is asked for before any transfer was split
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			r <= DEV_INIT;
		end else begin
			r <= next_r;
		end
	end

	// every bus output below is a register, never a decode
	assign bus.hready    = r.ready;
	assign bus.hresp     = r.resp;
	assign bus.split_req = r.split_req;
	assign sel_default   = r.sel_def;
	assign xfer_done     = r.done;
endmodule
`default_nettype wire

// ---- core/sbd_master.sv ----
// simple bus master issuing single transfers and reissuing on retry/split
`timescale 1ns/1ps
`default_nettype none
module sbd_master
	import sbd_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              reset,
	sbd_bus_if.mst                 bus,
	input  wire logic              req_valid,
	input  wire logic [ADDR_W-1:0] req_addr,
	output logic                   req_ready,
	output logic                   rsp_valid,
	output logic                   rsp_error
);
	typedef enum logic [1:0] {
		SBD_M_IDLE = 2'b00,
		SBD_M_ADDR = 2'b01,
		SBD_M_DATA = 2'b10,
		SBD_M_WAIT = 2'b11
	} sbd_mstate_e;

	typedef struct packed {
		sbd_mstate_e       st;
		logic [ADDR_W-1:0] addr;
		sbd_trans_e        trans;
		logic              rdy;
		logic              vld;
		logic              err;
	} sbd_mst_s;

	sbd_mst_s r;
	sbd_mst_s next_r;

	always_comb begin
		next_r = r;
		next_r.vld = 1'b0;
		next_r.rdy = 1'b0;
		case (r.st)
			SBD_M_IDLE: begin
				next_r.trans = SBD_TR_IDLE;
				if (req_valid) begin
					next_r.addr  = req_addr;
					next_r.trans = SBD_TR_NONSEQ;
					next_r.st    = SBD_M_ADDR;
				end
			end
			SBD_M_ADDR: if (bus.hready) begin
				next_r.trans = SBD_TR_IDLE; // RULE_07
				next_r.st    = SBD_M_DATA;
			end
			SBD_M_DATA: if (bus.hready) begin
				if (bus.hresp == SBD_RESP_RETRY || bus.hresp == SBD_RESP_SPLIT) begin
					next_r.trans = SBD_TR_NONSEQ; // RULE_15 RULE_20
					next_r.st    = SBD_M_ADDR;
				end else begin
					next_r.vld = 1'b1; // RULE_16
					next_r.err = (bus.hresp == SBD_RESP_ERROR);
					next_r.rdy = 1'b1;
					next_r.st  = SBD_M_WAIT;
				end
			end else if (bus.hresp != SBD_RESP_OKAY) begin
				next_r.trans = SBD_TR_IDLE; // RULE_15
			end
			SBD_M_WAIT: next_r.st = SBD_M_IDLE;
			default: next_r.st = SBD_M_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			r <= '{st: SBD_M_IDLE, addr: '0, trans: SBD_TR_IDLE, rdy: 1'b0, vld: 1'b0,
				err: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign bus.haddr  = r.addr; // RULE_04
	assign bus.htrans = r.trans;
	assign req_ready  = r.rdy;
	assign rsp_valid  = r.vld;
	assign rsp_error  = r.err;
endmodule
`default_nettype wire

// ---- tb/sbd_bus_monitor.sv ----
// interface-level checks of address decode and slave response timing
`timescale 1ns/1ps
`default_nettype none
module sbd_bus_monitor
	import sbd_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              reset,
	input  wire logic [ADDR_W-1:0] haddr,
	input  wire sbd_trans_e        htrans,
	input  wire logic              hready,
	input  wire sbd_resp_e         hresp,
	input  wire logic [SEL_W-1:0]  hsel
);
	logic [SEL_W-1:0] exp_sel;
	logic [5:0]       low_cnt;
	// four 4kB slaves from zero, everything else falls to the default slave
	always_comb exp_sel = (haddr < 32'h4000) ? (SEL_W'(1) << haddr[13:12]) : (SEL_W'(1) << DEF_IDX);
	always_ff @(posedge clock or posedge reset) begin
		if (reset) low_cnt <= 6'h00;
		else low_cnt <= hready ? 6'h00 : low_cnt + 6'h01;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	sel_decode_a:
		assert property (hsel == exp_sel) else $error("select decode wrong");
	region_span_a:
		assert property ($stable(haddr[ADDR_W-1:10]) |-> $stable(hsel)) else $error("select split a 1kB block");
	penult_code_a:
		assert property (!hready && hresp != SBD_RESP_OKAY |=> hready && $stable(hresp))
			else $error("two-cycle response not completed");
	two_cycle_a:
		assert property (hready && hresp != SBD_RESP_OKAY |-> $past(!hready) && $past(hresp) == hresp)
			else $error("non-okay response in one cycle");
	wait_okay_a:
		assert property (!hready ##1 !hready |-> $past(hresp) == SBD_RESP_OKAY) else $error("wait not okay");
	wait_bound_a:
		assert property (low_cnt <= 6'h11) else $error("too many wait states");
	hole_idle_a:
		assert property (hready && !sbd_is_active(htrans) && hsel[DEF_IDX] |=> hready && hresp == SBD_RESP_OKAY)
			else $error("idle to hole not zero-wait okay");
	hole_error_a:
		assert property (hready && sbd_is_active(htrans) && hsel[DEF_IDX]
			|=> !hready && hresp == SBD_RESP_ERROR ##1 hready && hresp == SBD_RESP_ERROR)
			else $error("hole access not answered with error");
endmodule
`default_nettype wire

// ---- tb/ahb_decoder_slave_response_tb.sv ----
// self-checking bench joining the master end and the decoder/slave end
`timescale 1ns/1ps
`default_nettype none
module ahb_decoder_slave_response_tb;
	import sbd_pkg::*;
	logic              clock, reset, req_valid, req_ready, rsp_valid, rsp_error;
	logic              data_avail, sel_default, err, dflt;
	logic              xfer_done, sreq, sdone, rdy;
	logic [ADDR_W-1:0] req_addr;
	logic [WAIT_W-1:0] cfg_wait;
	sbd_resp_e         cfg_resp;
	int                n_fail, n_checks;
	localparam logic [31:0] T_ADDR [9] = '{32'h0, 32'h1ffc, 32'h3000, 32'h2000, 32'h4000,
		32'hfffffffc, 32'h1000, 32'h0400, 32'h3ffc};
	localparam logic [4:0]  T_WAIT [9] = '{5'h0, 5'h3, 5'h10, 5'h1f, 5'h0, 5'h2, 5'h1, 5'h2, 5'h0};
	localparam sbd_resp_e   T_RESP [9] = '{SBD_RESP_OKAY, SBD_RESP_OKAY, SBD_RESP_ERROR,
		SBD_RESP_OKAY, SBD_RESP_OKAY, SBD_RESP_OKAY, SBD_RESP_RETRY, SBD_RESP_SPLIT, SBD_RESP_ERROR};
	sbd_bus_if bus ();
	sbd_decoder_slave i_sbd_decoder_slave (.clock(clock), .reset(reset), .bus(bus.dev),
		.cfg_wait(cfg_wait), .cfg_resp(cfg_resp), .data_avail(data_avail),
		.sel_default(sel_default), .xfer_done(xfer_done));
	sbd_master i_sbd_master (.clock(clock), .reset(reset), .bus(bus.mst), .req_valid(req_valid),
		.req_addr(req_addr), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_error(rsp_error));
	sbd_bus_monitor i_sbd_bus_monitor (.clock(clock), .reset(reset), .haddr(bus.haddr),
		.htrans(bus.htrans), .hready(bus.hready), .hresp(bus.hresp), .hsel(bus.hsel));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// sw is the cycle at which a stalling slave turns to okay; retry and split must reissue
	task automatic xfer(input logic [31:0] a, input logic [4:0] w, input sbd_resp_e r, input int sw);
		int i;
		cfg_wait <= w;
		cfg_resp <= r;
		data_avail <= (r != SBD_RESP_SPLIT);
		req_addr <= a;
		req_valid <= 1'b1;
		sreq = 1'b0;
		sdone = 1'b0;
		for (i = 0; i < 400; i++) begin
			// outputs are read half a period after the edge that launches them
			@(negedge clock);
			sreq = sreq | bus.split_req;
			sdone = sdone | xfer_done;
			if (rsp_valid === 1'b1) break;
			@(posedge clock);
			if (i == sw) begin
				cfg_resp <= SBD_RESP_OKAY;
				data_avail <= 1'b1;
			end
		end
		if (i == 400) begin
			n_fail++;
			summarize();
		end
		err = rsp_error;
		dflt = sel_default;
		rdy = req_ready;
		@(posedge clock);
		req_valid <= 1'b0;
		@(posedge clock);
	endtask
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		reset = 1'b1;
		req_valid = 1'b0;
		req_addr = '0;
		cfg_wait = '0;
		cfg_resp = SBD_RESP_OKAY;
		data_avail = 1'b1;
		n_fail = 0;
		n_checks = 0;
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		foreach (T_ADDR[k]) begin
			xfer(T_ADDR[k], T_WAIT[k], T_RESP[k], (T_RESP[k][1] ? 12 : -1));
			check(err, (T_ADDR[k] >= 32'h4000) || (T_RESP[k] == SBD_RESP_ERROR), "status");
			check(dflt, T_ADDR[k] >= 32'h4000, "default select");
			check(sdone, 1'b1, "completion pulse");
			check(rdy, 1'b1, "master finished");
			if (T_RESP[k] == SBD_RESP_SPLIT) check(sreq, 1'b1, "split request");
		end
		repeat (4) @(posedge clock);
		summarize();
	end
endmodule
`default_nettype wire
